// ===== common/wdog_regs.vh
// Register map, field positions, reset values and counts for the watchdog.
// Assumes a 32-bit Avalon-MM slave port with byte addresses.
// Functional notes
// [R01] Divider chain on system clock sets interval
// [R02] Two-bit select picks one of four intervals
// [R03] Timeout flag set at every interval end
// [R04] Interrupt needs flag, enable and global enable
// [R05] Interrupt and reset paths work independently
// [R06] Reset after 512 more clocks without restart
// [R07] Reset lasts two machine cycles, sets cause
// [R08] Restart bit clears counter, then self-clears
// [R09] Reset-enable bit gates reset, counter keeps running
// [R10] Any reset or software clears timeout flag
// [R11] Cause flag kept until software or power-fail
// [R12] Power-on disables; watchdog reset only restarts
// [R13] Software restarts watchdog before relying on it
// [R14] Protected bits change only after timed unlock
// [R15] Interval select resets to shortest interval
// [R16] Config bit seven picks RC or core clock
// [R17] Timeout flag stays set while counting continues
`ifndef WDOG_REGS_VH
`define WDOG_REGS_VH
// Byte offsets
`define WDOG_CTRL_OFS      8'h00
`define WDOG_IEN_OFS       8'h04
`define WDOG_GIE_OFS       8'h08
`define WDOG_TA_OFS        8'h0c
`define WDOG_STAT_OFS      8'h10
`define WDOG_MASK_OFS      8'h14
`define WDOG_CFG_OFS       8'h18
// Control register fields
`define WDOG_SEL_HI        5
`define WDOG_SEL_LO        4
`define WDOG_TOF_BIT       3
`define WDOG_RCF_BIT       2
`define WDOG_REN_BIT       1
`define WDOG_RST_BIT       0
// Other fields
`define WDOG_IEN_BIT       4
`define WDOG_GIE_BIT       0
`define WDOG_CSRC_BIT      7
`define WDOG_ST_TO_BIT     0
`define WDOG_ST_WR_BIT     1
// Reset values
`define WDOG_SEL_RST       2'h0
`define WDOG_MASK_RST      2'h0
`define WDOG_CFG_RST       1'h0
// Timed access unlock bytes and window
`define WDOG_TA_KEY1       8'haa
`define WDOG_TA_KEY2       8'h55
`define WDOG_TA_WIN        3'h4
// Interval ends (count minus one)
`define WDOG_LIM0          27'h001ffff
`define WDOG_LIM1          27'h00fffff
`define WDOG_LIM2          27'h07fffff
`define WDOG_LIM3          27'h3ffffff
// Grace clocks after timeout, minus one
`define WDOG_GRACE_LAST    10'h1ff
// Reset hold: two machine cycles of four clocks, minus one
`define WDOG_HOLD_LAST     3'h7
`endif

// ===== hdl/wdog_div_counter.v
// Divider counter of the watchdog: counts ticks up to a limit and wraps.
// Assumes tick and clear come from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
module wdog_div_counter (
   // Clock and reset
   input  wire        core_clk_i,
   input  wire        rst_i,
   // Control
   input  wire        clear_i,
   input  wire        tick_i,
   input  wire [26:0] limit_i,
   // Status
   output reg  [26:0] count_o,
   output reg         wrap_o
);

   // Counter: clear wins, wraps at the limit and flags the wrap
   always @(posedge core_clk_i) begin
      if (rst_i || clear_i) begin
         count_o <= 27'h0000000;
         wrap_o  <= 1'b0;
      end else if (tick_i && (count_o >= limit_i)) begin
         count_o <= 27'h0000000;                 // [R01] [R03]
         wrap_o  <= 1'b1;
      end else begin
         if (tick_i) begin
            count_o <= count_o + 27'h0000001;
         end
         wrap_o <= 1'b0;
      end
   end

endmodule // wdog_div_counter
`default_nettype wire

// ===== hdl/wdog_timer.v
// Watchdog timer with interval select, timeout flag and delayed reset.
// Assumes an Avalon-MM master on core_clk_i; por_i and rc_clk_i are
// asynchronous pins and are synchronised here.
//
// Decided for this implementation: the Avalon-MM slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "wdog_regs.vh"
module wdog_timer (
   // Clock and reset
   input  wire        core_clk_i,
   input  wire        rst_i,
   // Pins
   input  wire        por_i,
   input  wire        rc_clk_i,
   // Avalon-MM slave
   input  wire [7:0]  address_i,
   input  wire        read_i,
   input  wire        write_i,
   input  wire [31:0] writedata_i,
   input  wire [3:0]  byteenable_i,
   output reg  [31:0] readdata_o,
   output reg         waitrequest_o,
   // To the processor core
   output reg         wdog_irq_o,
   output reg         sys_reset_o,
   output reg         irq_o
);

   // Grace state machine codes
   localparam [2:0] ST_IDLE  = 3'b001;
   localparam [2:0] ST_GRACE = 3'b010;
   localparam [2:0] ST_RST   = 3'b100;

   // Limit of the divider for an interval select code
   function [26:0] sel_limit;
      input [1:0] sel;
      begin
         case (sel)
            2'h0:    sel_limit = `WDOG_LIM0;
            2'h1:    sel_limit = `WDOG_LIM1;
            2'h2:    sel_limit = `WDOG_LIM2;
            default: sel_limit = `WDOG_LIM3;
         endcase
      end
   endfunction

   // Write strobe for low byte at a given offset
   function wr_hit;
      input [7:0] adr;
      input [7:0] ofs;
      input       wr;
      input       be0;
      begin
         wr_hit = wr && be0 && (adr == ofs);
      end
   endfunction

   // Synchronisers for pins
   reg        por_meta_ff;    // First stage, power-on pin
   reg        por_ff;         // Second stage, power-on pin
   reg        rc_meta_ff;     // First stage, RC clock pin
   reg        rc_ff;          // Second stage, RC clock pin
   reg        rc_last_ff;     // Previous RC level for edge detect

   // Register file
   reg  [1:0] sel_ff;         // Interval select
   reg        tof_ff;         // Timeout flag
   reg        rcf_ff;         // Watchdog reset cause flag
   reg        ren_ff;         // Reset on timeout enable
   reg        restart_ff;     // Restart bit, self clearing
   reg        ien_ff;         // Watchdog interrupt enable
   reg        gie_ff;         // Global interrupt enable
   reg        csrc_ff;        // Clock source: 1 = RC oscillator
   reg  [1:0] stat_ff;        // Sticky event status
   reg  [1:0] mask_ff;        // Event mask
   reg        run_ff;         // Watchdog running

   // Timed access
   reg        ta_arm_ff;      // First key seen
   reg  [2:0] ta_win_ff;      // Cycles left in unlock window

   // Grace and reset sequencing
   reg  [2:0] state_ff;       // One-hot state
   reg  [2:0] nxt_state;      // Next state
   reg  [9:0] grace_ff;       // Ticks since timeout
   reg  [2:0] hold_ff;        // Clocks of reset held

   // Bus handshake and internal strobes
   wire       wr_now;         // Write taken at this edge
   wire       ta_open;        // Unlock window open
   wire       ctrl_wr;        // Control register written
   wire       prot_wr;        // Protected bits written
   wire       tick;           // Watchdog clock tick
   wire       cnt_clear;      // Clear the divider
   wire       timeout_ev;     // Interval completed
   wire       wrst_ev;        // Watchdog reset begins
   reg  [31:0] rd_mux;        // Read data selection

   assign wr_now  = write_i && !waitrequest_o;
   assign ta_open = (ta_win_ff != 3'h0);
   assign ctrl_wr = wr_hit(address_i, `WDOG_CTRL_OFS, wr_now, byteenable_i[0]);
   assign prot_wr = ctrl_wr && ta_open;                   // [R14]

   // Pin synchronisers; only second stages and rc_last_ff are read by logic
   always @(posedge core_clk_i) begin
      if (rst_i) begin
         por_meta_ff <= 1'b0;
         por_ff      <= 1'b0;
         rc_meta_ff  <= 1'b0;
         rc_ff       <= 1'b0;
         rc_last_ff  <= 1'b0;
      end else begin
         por_meta_ff <= por_i;
         por_ff      <= por_meta_ff;
         rc_meta_ff  <= rc_clk_i;
         rc_ff       <= rc_meta_ff;
         rc_last_ff  <= rc_ff;
      end
   end

   // Tick on every core clock, or on RC rising edge
   assign tick = csrc_ff ? (rc_ff && !rc_last_ff) : 1'b1;  // [R16] [R01]

   // Divider is held while stopped, on restart and during own reset
   assign cnt_clear = !run_ff || restart_ff || (state_ff == ST_RST); // [R08] [R12]

   // Divider chain
   wdog_div_counter u_div (
      .core_clk_i (core_clk_i),
      .rst_i      (rst_i),
      .clear_i    (cnt_clear),
      .tick_i     (tick),
      .limit_i    (sel_limit(sel_ff)),                    // [R02]
      .count_o    (),
      .wrap_o     (timeout_ev)
   );

   assign wrst_ev = (state_ff != ST_RST) && (nxt_state == ST_RST);

   // Avalon handshake: one wait state, then the request is taken
   always @(posedge core_clk_i) begin
      if (rst_i) begin
         waitrequest_o <= 1'b1;
      end else begin
         waitrequest_o <= !((read_i || write_i) && waitrequest_o);
      end
   end

   // Read data selection; unmapped offsets read zero
   always @* begin
      rd_mux = 32'h00000000;
      case (address_i)
         `WDOG_CTRL_OFS: begin
            rd_mux[`WDOG_SEL_HI:`WDOG_SEL_LO] = sel_ff;
            rd_mux[`WDOG_TOF_BIT] = tof_ff;
            rd_mux[`WDOG_RCF_BIT] = rcf_ff;
            rd_mux[`WDOG_REN_BIT] = ren_ff;
            rd_mux[`WDOG_RST_BIT] = restart_ff;
         end
         `WDOG_IEN_OFS:  rd_mux[`WDOG_IEN_BIT]  = ien_ff;
         `WDOG_GIE_OFS:  rd_mux[`WDOG_GIE_BIT]  = gie_ff;
         `WDOG_TA_OFS:   rd_mux[0]              = ta_open;
         `WDOG_STAT_OFS: rd_mux[1:0]            = stat_ff;
         `WDOG_MASK_OFS: rd_mux[1:0]            = mask_ff;
         `WDOG_CFG_OFS:  rd_mux[`WDOG_CSRC_BIT] = csrc_ff;
         default:        rd_mux = 32'h00000000;
      endcase
   end

   // Read data are loaded in the wait cycle and stand at the taking edge
   always @(posedge core_clk_i) begin
      if (rst_i) begin
         readdata_o <= 32'h00000000;
      end else if (read_i && waitrequest_o) begin
         readdata_o <= rd_mux;
      end
   end

   // Timed access: first key arms, second key opens a short window
   always @(posedge core_clk_i) begin
      if (rst_i || por_ff) begin
         ta_arm_ff <= 1'b0;
         ta_win_ff <= 3'h0;
      end else if (wr_hit(address_i, `WDOG_TA_OFS, wr_now, byteenable_i[0])) begin
         // Key sequence: first key arms, second key right after it opens
         ta_arm_ff <= (writedata_i[7:0] == `WDOG_TA_KEY1);
         if (ta_arm_ff && (writedata_i[7:0] == `WDOG_TA_KEY2)) begin
            ta_win_ff <= `WDOG_TA_WIN;                    // [R14]
         end else begin
            ta_win_ff <= 3'h0;
         end
      end else if (ctrl_wr) begin                         // Control write closes the window
         ta_arm_ff <= 1'b0;
         ta_win_ff <= 3'h0;
      end else if (ta_open) begin                         // Window runs down
         ta_win_ff <= ta_win_ff - 3'h1;
      end
   end

   // Interval select: free to write, resets to the shortest interval
   always @(posedge core_clk_i) begin
      if (rst_i || por_ff) begin
         sel_ff <= `WDOG_SEL_RST;                         // [R15]
      end else if (ctrl_wr) begin
         sel_ff <= writedata_i[`WDOG_SEL_HI:`WDOG_SEL_LO]; // [R02]
      end
   end

   // Restart bit, written under unlock and cleared by hardware next cycle;
   // power-on stops the watchdog and only a restart starts it again
   always @(posedge core_clk_i) begin
      if (rst_i || por_ff) begin
         restart_ff <= 1'b0;
         run_ff     <= 1'b0;                              // [R12]
      end else begin
         restart_ff <= prot_wr && writedata_i[`WDOG_RST_BIT]; // [R08] [R13]
         if (restart_ff) begin
            run_ff <= 1'b1;
         end
      end
   end

   // Reset-on-timeout enable, protected
   always @(posedge core_clk_i) begin
      if (rst_i || por_ff) begin
         ren_ff <= 1'b0;
      end else if (prot_wr) begin
         ren_ff <= writedata_i[`WDOG_REN_BIT];            // [R09] [R14]
      end
   end

   // Timeout flag: set wins over clear, cleared by every reset
   always @(posedge core_clk_i) begin
      if (rst_i || por_ff || (state_ff == ST_RST)) begin
         tof_ff <= 1'b0;                                  // [R10]
      end else if (timeout_ev) begin
         tof_ff <= 1'b1;                                  // [R03] [R17]
      end else if (prot_wr && !writedata_i[`WDOG_TOF_BIT]) begin
         tof_ff <= 1'b0;                                  // [R10] [R14]
      end
   end

   // Reset cause flag: only power-fail or software clears it
   always @(posedge core_clk_i) begin
      if (rst_i || por_ff) begin
         rcf_ff <= 1'b0;                                  // [R11]
      end else if (wrst_ev) begin
         rcf_ff <= 1'b1;                                  // [R07]
      end else if (ctrl_wr && !writedata_i[`WDOG_RCF_BIT]) begin
         rcf_ff <= 1'b0;                                  // [R11]
      end
   end

   // Interrupt enables and clock source configuration
   always @(posedge core_clk_i) begin
      if (rst_i || por_ff) begin
         ien_ff  <= 1'b0;
         gie_ff  <= 1'b0;
         csrc_ff <= `WDOG_CFG_RST;
      end else begin
         if (wr_hit(address_i, `WDOG_IEN_OFS, wr_now, byteenable_i[0])) begin // Individual enable
            ien_ff <= writedata_i[`WDOG_IEN_BIT];
         end
         if (wr_hit(address_i, `WDOG_GIE_OFS, wr_now, byteenable_i[0])) begin // Global enable
            gie_ff <= writedata_i[`WDOG_GIE_BIT];
         end
         if (wr_hit(address_i, `WDOG_CFG_OFS, wr_now, byteenable_i[0])) begin // Clock source
            csrc_ff <= writedata_i[`WDOG_CSRC_BIT];       // [R16]
         end
      end
   end

   // Sticky status, write one to clear, event wins over clear
   always @(posedge core_clk_i) begin
      if (rst_i || por_ff) begin
         stat_ff <= 2'h0;
      end else begin
         if (timeout_ev) begin
            stat_ff[`WDOG_ST_TO_BIT] <= 1'b1;
         end else if (wr_hit(address_i, `WDOG_STAT_OFS, wr_now, byteenable_i[0]) &&
                      writedata_i[`WDOG_ST_TO_BIT]) begin
            stat_ff[`WDOG_ST_TO_BIT] <= 1'b0;
         end
         if (wrst_ev) begin
            stat_ff[`WDOG_ST_WR_BIT] <= 1'b1;
         end else if (wr_hit(address_i, `WDOG_STAT_OFS, wr_now, byteenable_i[0]) &&
                      writedata_i[`WDOG_ST_WR_BIT]) begin
            stat_ff[`WDOG_ST_WR_BIT] <= 1'b0;
         end
      end
   end

   // Mask register
   always @(posedge core_clk_i) begin
      if (rst_i || por_ff) begin
         mask_ff <= `WDOG_MASK_RST;
      end else if (wr_hit(address_i, `WDOG_MASK_OFS, wr_now, byteenable_i[0])) begin
         mask_ff <= writedata_i[1:0];
      end
   end

   // Grace and reset sequencing, next state
   always @* begin
      nxt_state = state_ff;
      case (state_ff)
         ST_IDLE: begin
            // Wait for an interval to end
            if (timeout_ev) begin
               nxt_state = ST_GRACE;                      // [R06]
            end
         end
         ST_GRACE: begin
            // Restart aborts; otherwise count the extra clocks
            if (restart_ff || !run_ff) begin
               nxt_state = ST_IDLE;                       // [R06]
            end else if (tick && (grace_ff == `WDOG_GRACE_LAST)) begin
               nxt_state = ren_ff ? ST_RST : ST_IDLE;     // [R09] [R05]
            end
         end
         ST_RST: begin
            // Hold the system reset
            if (hold_ff == `WDOG_HOLD_LAST) begin
               nxt_state = ST_IDLE;                       // [R07]
            end
         end
         default: nxt_state = ST_IDLE;
      endcase
   end

   // Grace and reset sequencing, registers
   always @(posedge core_clk_i) begin
      if (rst_i || por_ff) begin
         state_ff <= ST_IDLE;
         grace_ff <= 10'h000;
         hold_ff  <= 3'h0;
      end else begin
         state_ff <= nxt_state;
         // Grace counter runs only in its state
         if (state_ff != ST_GRACE) begin
            grace_ff <= 10'h000;
         end else if (tick) begin
            grace_ff <= grace_ff + 10'h001;               // [R06]
         end
         // Hold counter runs only while resetting
         if (state_ff != ST_RST) begin
            hold_ff <= 3'h0;
         end else begin
            hold_ff <= hold_ff + 3'h1;                    // [R07]
         end
      end
   end

   // Outputs, all registered
   always @(posedge core_clk_i) begin
      if (rst_i || por_ff) begin
         sys_reset_o <= 1'b0;
         wdog_irq_o  <= 1'b0;
         irq_o       <= 1'b0;
      end else begin
         sys_reset_o <= (nxt_state == ST_RST);            // [R07] [R12]
         wdog_irq_o  <= tof_ff && ien_ff && gie_ff;       // [R04] [R05]
         irq_o       <= |(stat_ff & mask_ff);
      end
   end

endmodule // wdog_timer
`default_nettype wire

// ===== testbench/wdog_timer_assertions.sv
// Checker for the watchdog ports: bus timing, reset pulse and flags.
// Assumes it is bound to every wdog_timer instance.
`timescale 1ns/1ps
`default_nettype none
module wdog_timer_assertions (
   // Clock and reset
   input wire logic        core_clk_i,
   input wire logic        rst_i,
   // Pin and bus
   input wire logic        por_i,
   input wire logic [7:0]  address_i,
   input wire logic        read_i,
   input wire logic        write_i,
   input wire logic [31:0] readdata_o,
   input wire logic        waitrequest_o,
   // Core side
   input wire logic        wdog_irq_o,
   input wire logic        sys_reset_o,
   input wire logic        irq_o
);
   localparam int GAP_MIN = 131500;  // Full interval plus grace, less slack
   logic [3:0]  quiet_ff;            // Cycles since a write or reset
   logic [17:0] since_ff;            // Cycles since the last reset pulse
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (rst_i);
   // Quiet counter, saturating
   always @(posedge core_clk_i) begin
      if (rst_i || write_i || sys_reset_o || por_i)
         quiet_ff <= 4'h0;
      else if (quiet_ff != 4'hf)
         quiet_ff <= quiet_ff + 4'h1;
   end
   // Gap counter, full after reset
   always @(posedge core_clk_i) begin
      if (rst_i)
         since_ff <= 18'h3ffff;
      else if (sys_reset_o)
         since_ff <= 18'h0;
      else if (since_ff != 18'h3ffff)
         since_ff <= since_ff + 18'h1;
   end
   property p_wait; $rose(read_i || write_i) |-> waitrequest_o ##1 !waitrequest_o; endproperty
   a_wait: assert property (p_wait) else $error("no single wait state");
   property p_wait_back; (read_i || write_i) && !waitrequest_o |=> waitrequest_o; endproperty
   a_wait_back: assert property (p_wait_back) else $error("wait not raised again");
   property p_unmapped; read_i && !waitrequest_o && address_i == 8'h1c |-> readdata_o == 32'h0;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   property p_rst_len; $rose(sys_reset_o) |-> sys_reset_o [*8] ##1 !sys_reset_o; endproperty
   a_rst_len: assert property (p_rst_len) else $error("reset pulse length wrong");
   property p_rst_gap; $rose(sys_reset_o) |-> since_ff >= GAP_MIN; endproperty
   a_rst_gap: assert property (p_rst_gap) else $error("reset came too soon");
   property p_after_rst;
      $fell(rst_i) |-> !wdog_irq_o && !sys_reset_o && !irq_o && waitrequest_o && readdata_o == 0;
   endproperty
   a_after_rst: assert property (p_after_rst) else $error("outputs not cleared");
   property p_por; por_i [*6] |-> !wdog_irq_o && !sys_reset_o && !irq_o; endproperty
   a_por: assert property (p_por) else $error("power-on did not clear");
   property p_flag_stays; $fell(wdog_irq_o) || $fell(irq_o) |-> quiet_ff < 4'h8; endproperty
   a_flag_stays: assert property (p_flag_stays) else $error("flag dropped alone");
endmodule // wdog_timer_assertions
bind wdog_timer wdog_timer_assertions u_chk (.core_clk_i(core_clk_i), .rst_i(rst_i),
   .por_i(por_i), .address_i(address_i), .read_i(read_i), .write_i(write_i),
   .readdata_o(readdata_o), .waitrequest_o(waitrequest_o), .wdog_irq_o(wdog_irq_o),
   .sys_reset_o(sys_reset_o), .irq_o(irq_o));
`default_nettype wire

// ===== testbench/wdog_core_model.sv
// Model of the core that takes the watchdog interrupt and reset.
// Assumes both inputs are registered on core_clk_i.
`timescale 1ns/1ps
`default_nettype none
module wdog_core_model (
   // Clock
   input wire logic        core_clk_i,
   // From the watchdog
   input wire logic        sys_reset_i,
   input wire logic        wdog_irq_i,
   // Observations
   output logic [7:0]      n_reset_o,  // Reset pulses seen
   output logic [7:0]      rst_len_o,  // Length of the last pulse
   output logic [7:0]      n_irq_o     // Interrupt requests taken
);
   logic [7:0] run_ff;   // Length of the pulse in progress
   logic       irq_ff;   // Interrupt level one cycle ago
   initial begin
      run_ff = 0; irq_ff = 0; n_reset_o = 0; rst_len_o = 0; n_irq_o = 0;
   end
   // Measure the reset pulse and count interrupt requests
   always @(posedge core_clk_i) begin
      irq_ff <= wdog_irq_i;
      if (wdog_irq_i && !irq_ff)
         n_irq_o <= n_irq_o + 8'h1;
      if (sys_reset_i) begin
         run_ff <= run_ff + 8'h1;
      end else if (run_ff != 0) begin
         rst_len_o <= run_ff;
         n_reset_o <= n_reset_o + 8'h1;
         run_ff    <= 8'h0;
      end
   end
endmodule // wdog_core_model
`default_nettype wire

// ===== testbench/tb_wdog_timer.sv
// Self-checking bench for the watchdog: register table, then timeout path.
// Assumes the shortest interval is left selected for the long run.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin n_mismatch++; \
   $display("[ERR] %0t got %h want %h", $time, (a), (b)); end end
module tb_wdog_timer;
   typedef struct packed {logic w; logic [7:0] a; logic [31:0] d; logic [31:0] e;} row_t;
   logic core_clk_i, rst_i, por_i, rc_clk_i, read_i, write_i;
   logic [7:0]  address_i;
   logic [31:0] writedata_i, q;
   logic [3:0]  byteenable_i;
   wire [31:0]  readdata_o;
   wire         waitrequest_o, wdog_irq_o, sys_reset_o, irq_o;
   wire [7:0]   n_reset, rst_len, n_irq;
   int n_mismatch = 0, n_compared = 0, cyc = 0, c0, c1, c2;
   row_t rows [18] = '{
      '{0, 8'h00, 0, 0}, '{0, 8'h04, 0, 0}, '{0, 8'h08, 0, 0}, '{0, 8'h10, 0, 0},
      '{0, 8'h14, 0, 0}, '{0, 8'h18, 0, 0}, '{1, 8'h04, 32'h10, 0}, '{0, 8'h04, 0, 32'h10},
      '{1, 8'h08, 1, 0}, '{0, 8'h08, 0, 1}, '{1, 8'h14, 3, 0}, '{0, 8'h14, 0, 3},
      '{1, 8'h1c, 32'hff, 0}, '{0, 8'h1c, 0, 0}, '{1, 8'h18, 32'h80, 0},
      '{0, 8'h18, 0, 32'h80}, '{1, 8'h00, 32'h1b, 0}, '{0, 8'h00, 0, 32'h10}};
   // Design, core model
   wdog_timer u_dut (.core_clk_i(core_clk_i), .rst_i(rst_i), .por_i(por_i),
      .rc_clk_i(rc_clk_i), .address_i(address_i), .read_i(read_i), .write_i(write_i),
      .writedata_i(writedata_i), .byteenable_i(byteenable_i), .readdata_o(readdata_o),
      .waitrequest_o(waitrequest_o), .wdog_irq_o(wdog_irq_o), .sys_reset_o(sys_reset_o),
      .irq_o(irq_o));
   wdog_core_model u_core (.core_clk_i(core_clk_i), .sys_reset_i(sys_reset_o),
      .wdog_irq_i(wdog_irq_o), .n_reset_o(n_reset), .rst_len_o(rst_len), .n_irq_o(n_irq));
   // Clock and cycle count
   always #2.5 core_clk_i = ~core_clk_i;
   always @(posedge core_clk_i) cyc <= cyc + 1;
   // One bus access, held until waitrequest is seen low
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r);
      int k;
      k = 0;
      @(posedge core_clk_i);
      address_i   <= a;
      writedata_i <= d;
      write_i     <= w;
      read_i      <= ~w;
      // Waitrequest is sampled at rising edges; the request is taken where it is low
      @(posedge core_clk_i);
      while (waitrequest_o !== 1'b0 && k < 16) begin
         @(posedge core_clk_i);
         k++;
      end
      r = readdata_o;
      write_i <= 1'b0;
      read_i  <= 1'b0;
      `CHK(k < 16, 1'b1)
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d, q);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0, q);
      `CHK(q, e)
   endtask
   // Wait for interrupt (0) or reset (1), bounded; returns the cycle count
   task automatic wait_hi(input logic s, output int c);
      int k;
      k = 0;
      while ((s ? sys_reset_o : wdog_irq_o) !== 1'b1 && k < 140000) begin
         @(negedge core_clk_i);
         k++;
      end
      c = cyc;
   endtask
   task automatic summarize();
      $display("compared %0d mismatched %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // Watchdog against a hang
   initial begin
      #1000000;
      n_mismatch++;
      $display("[ERR] %0t run took too long", $time);
      summarize();
   end
   // Main sequence
   initial begin
      core_clk_i = 0; rst_i = 1; por_i = 0; rc_clk_i = 0; read_i = 0; write_i = 0;
      address_i = 0; writedata_i = 0; byteenable_i = 4'h1;
      repeat (20) @(posedge core_clk_i);
      rst_i <= 1'b0;
      foreach (rows[i]) begin
         bus(rows[i].w, rows[i].a, rows[i].d, q);
         if (!rows[i].w) `CHK(q, rows[i].e)
      end
      wr(8'h18, 32'h0);
      $display("test register table done");
      wr(8'h0c, 32'haa);
      wr(8'h0c, 32'h55);
      wr(8'h00, 32'h03);
      c0 = cyc;
      wait_hi(1'b0, c1);
      `CHK((c1 - c0) >= 131072 && (c1 - c0) <= 131080, 1'b1)
      @(negedge core_clk_i);
      `CHK(irq_o, 1'b1)
      rd(8'h00, 32'h0a);
      wait_hi(1'b1, c2);
      `CHK((c2 - c1) >= 510 && (c2 - c1) <= 516, 1'b1)
      repeat (12) @(negedge core_clk_i);
      `CHK(rst_len, 8'h08)
      `CHK({n_reset, n_irq}, 16'h0101)
      rd(8'h00, 32'h06);
      rd(8'h10, 32'h03);
      `CHK(irq_o, 1'b1)
      wr(8'h14, 32'h0);
      repeat (2) @(negedge core_clk_i);
      `CHK(irq_o, 1'b0)
      wr(8'h14, 32'h3);
      wr(8'h10, 32'h3);
      rd(8'h10, 32'h0);
      `CHK(irq_o, 1'b0)
      wr(8'h00, 32'h02);
      rd(8'h00, 32'h02);
      $display("test timeout and reset done");
      rst_i <= 1'b1;
      repeat (3) @(posedge core_clk_i);
      rst_i <= 1'b0;
      rd(8'h00, 32'h0);
      wr(8'h04, 32'h10);
      por_i <= 1'b1;
      repeat (8) @(posedge core_clk_i);
      por_i <= 1'b0;
      repeat (4) @(posedge core_clk_i);
      rd(8'h04, 32'h0);
      $display("test resets done");
      summarize();
   end
endmodule // tb_wdog_timer
`default_nettype wire
